// file: kwu_consts.svh
/*
 * Constants of the key wake unit: register offsets, field positions,
 * reset values. Assumes inclusion by bare name from kwu_pkg and the top.
 */
`ifndef KWU_CONSTS_SVH
`define KWU_CONSTS_SVH

// ==========================================================
// Register offsets
`define KWU_OFS_STATUS_CONTROL  4'h0
`define KWU_OFS_PIN_ENABLE      4'h1
`define KWU_OFS_IRQ_STATUS      4'h2
`define KWU_OFS_IRQ_MASK        4'h3
`define KWU_OFS_PIN_LEVEL       4'h4

// ==========================================================
// Status/control fields
`define KWU_BIT_MODE            0
`define KWU_BIT_IRQ_ENABLE      1
`define KWU_BIT_ACK             2
`define KWU_BIT_PENDING         3
`define KWU_POL_LSB             4
`define KWU_POL_MSB             7

// Sticky event status fields
`define KWU_EVT_EDGE            0
`define KWU_EVT_WAKE            1

// ==========================================================
// Reset values
`define KWU_RST_BYTE            8'h00
`define KWU_RST_EVT             2'h0
`define KWU_RST_POL             4'h0
`define KWU_RST_LEVEL           1'b1

`endif

// file: kwu_pkg.sv
/*
 * Types of the key wake unit.
 * Assumes kwu_consts.svh is on the include path.
 */
`include "kwu_consts.svh"

package kwu_pkg;
    typedef logic [7:0] kwu_byte_type;
    typedef logic [3:0] kwu_addr_type;
    typedef logic [1:0] kwu_evt_type;
endpackage

// file: kwu_key_wake_unit.sv
/*
 * Key wake unit: eight port pins, per-pin enable, edge or edge-and-level
 * detection, common pending flag, interrupt and stop-mode wake.
 * Assumes one clock MCLK, synchronous active-high RST, a simple register
 * port with read data one cycle after the read strobe, and raw pins that
 * are asynchronous to MCLK.
 */
// Chosen here: the strobed register port and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "kwu_consts.svh"

module kwu_key_wake_unit (
    input  wire logic                 MCLK,        // 125 MHz clock
    input  wire logic                 RST,         // Sync reset, high
    input  wire kwu_pkg::kwu_addr_type ADDR,       // Register address
    input  wire kwu_pkg::kwu_byte_type WDATA,      // Write data
    input  wire logic                 WR,          // Write strobe
    input  wire logic                 RD,          // Read strobe
    output var  kwu_pkg::kwu_byte_type RDATA,      // Read data
    input  wire kwu_pkg::kwu_byte_type PIN_IN,     // Raw port pins
    input  wire kwu_pkg::kwu_byte_type PORT_DIR,   // Port direction reg
    input  wire kwu_pkg::kwu_byte_type PORT_PULL,  // Port pull enable
    input  wire logic                 STOP_MODE,   // Clocks halted
    output var  kwu_pkg::kwu_byte_type PIN_DIR,    // Effective direction
    output var  kwu_pkg::kwu_byte_type PULL_UP,    // Pullup enables
    output var  kwu_pkg::kwu_byte_type PULL_DOWN,  // Pulldown enables
    output var  logic                 KEY_IRQ,     // CPU request
    output var  logic                 IRQ,         // Masked sticky irq
    output var  logic                 WAKE         // Stop/wait wake
);

    // ==========================================================
    // Registers
    kwu_pkg::kwu_byte_type enable_r;
    logic [3:0]            polarity_r;
    logic                  mode_r;
    logic                  irq_en_r;
    logic                  pending_r;
    kwu_pkg::kwu_evt_type  evt_r;
    kwu_pkg::kwu_evt_type  mask_r;
    kwu_pkg::kwu_byte_type prev_asserted_r;
    wire kwu_pkg::kwu_byte_type pin_level;   // Filtered pin levels

    // ==========================================================
    // Decode
    wire logic wr_sc   = WR && (ADDR == `KWU_OFS_STATUS_CONTROL);
    wire logic wr_pe   = WR && (ADDR == `KWU_OFS_PIN_ENABLE);
    wire logic wr_ist  = WR && (ADDR == `KWU_OFS_IRQ_STATUS);
    wire logic wr_imk  = WR && (ADDR == `KWU_OFS_IRQ_MASK);
    wire logic ack_wr  = wr_sc && WDATA[`KWU_BIT_ACK];

    // ==========================================================
    // Detection
    // Lower nibble is always active low; upper follows polarity
    wire kwu_pkg::kwu_byte_type pol_high = {polarity_r, 4'h0};
    wire kwu_pkg::kwu_byte_type asserted =
        (pin_level ^ ~pol_high) & enable_r;
    // Newly asserted pins; in edge-and-level mode only while every other enabled pin was idle
    wire kwu_pkg::kwu_byte_type rose_act = asserted & ~prev_asserted_r;
    wire logic others_idle =
        ((prev_asserted_r & enable_r) == 8'h00);
    wire logic edge_evt = (rose_act != 8'h00) &&
                          (!mode_r || others_idle);
    wire logic level_hold = mode_r && (asserted != 8'h00);
    wire logic set_pend   = edge_evt || level_hold;

    // Set wins over acknowledge
    wire logic pending_nxt = set_pend ? 1'b1 :
                             (ack_wr ? 1'b0 : pending_r);

    // Raw-pin asynchronous level path for stop mode
    wire kwu_pkg::kwu_byte_type raw_act = (PIN_IN ^ ~pol_high) & enable_r;
    // Request follows next flag and enable, so it never lags a read
    wire logic irq_en_nxt = wr_sc ? WDATA[`KWU_BIT_IRQ_ENABLE] : irq_en_r;
    wire logic req_nxt    = pending_nxt && irq_en_nxt;
    wire logic wake_nxt   = STOP_MODE ? (raw_act != 8'h00)
                                      : req_nxt;

    wire kwu_pkg::kwu_evt_type evt_set = {wake_nxt, edge_evt};
    wire kwu_pkg::kwu_evt_type evt_nxt =
        (evt_r & ~(wr_ist ? WDATA[1:0] : 2'h0)) | evt_set;

    wire kwu_pkg::kwu_byte_type sc_read =
        {polarity_r, pending_r, 1'b0, irq_en_r, mode_r};
    wire kwu_pkg::kwu_byte_type rd_mux =
        (ADDR == `KWU_OFS_STATUS_CONTROL) ? sc_read :
        (ADDR == `KWU_OFS_PIN_ENABLE)     ? enable_r :
        (ADDR == `KWU_OFS_IRQ_STATUS)     ? {6'h00, evt_r} :
        (ADDR == `KWU_OFS_IRQ_MASK)       ? {6'h00, mask_r} :
        (ADDR == `KWU_OFS_PIN_LEVEL)      ? pin_level : 8'h00;

    // Rising-polarity enabled upper pins swap pullup for pulldown
    wire kwu_pkg::kwu_byte_type use_down = pol_high & enable_r;

    // ==========================================================
    // Input synchronisers, one per pin
    for (genvar gi = 0; gi < 8; gi++) begin : g_pin
        kwu_pin_sync sync_u (
            .clk   (MCLK),
            .rst   (RST),
            .pin   (PIN_IN[gi]),
            .level (pin_level[gi])
        );
    end

    // ==========================================================
    // Control and status
    always_ff @(posedge MCLK) begin
        if (RST) begin
            enable_r        <= `KWU_RST_BYTE;
            polarity_r      <= `KWU_RST_POL;
            mode_r          <= 1'b0;
            irq_en_r        <= 1'b0;
            pending_r       <= 1'b0;
            evt_r           <= `KWU_RST_EVT;
            mask_r          <= `KWU_RST_EVT;
            prev_asserted_r <= `KWU_RST_BYTE;
        end else begin
            if (wr_sc) begin
                polarity_r <= WDATA[`KWU_POL_MSB:`KWU_POL_LSB];
                mode_r     <= WDATA[`KWU_BIT_MODE];
                irq_en_r   <= WDATA[`KWU_BIT_IRQ_ENABLE];
            end
            if (wr_pe) begin
                enable_r <= WDATA;
            end
            if (wr_imk) begin
                mask_r <= WDATA[1:0];
            end
            pending_r       <= pending_nxt;
            evt_r           <= evt_nxt;
            prev_asserted_r <= asserted;
        end
    end

    // ==========================================================
    // Registered outputs
    always_ff @(posedge MCLK) begin
        if (RST) begin
            RDATA     <= 8'h00;
            PIN_DIR   <= 8'h00;
            PULL_UP   <= 8'h00;
            PULL_DOWN <= 8'h00;
            KEY_IRQ   <= 1'b0;
            IRQ       <= 1'b0;
            WAKE      <= 1'b0;
        end else begin
            RDATA     <= RD ? rd_mux : 8'h00;
            PIN_DIR   <= PORT_DIR & ~enable_r;
            PULL_UP   <= PORT_PULL & ~use_down;
            PULL_DOWN <= PORT_PULL & use_down;
            KEY_IRQ   <= req_nxt;
            IRQ       <= (evt_nxt & mask_r) != 2'h0;
            WAKE      <= wake_nxt;
        end
    end

endmodule

// ==========================================================
// Pin synchroniser
// Three stages; a change counts once stages 2 and 3 agree, so a
// one-cycle glitch or a metastable sample never reaches the detector.
module kwu_pin_sync #(
    parameter logic IDLE_LEVEL = `KWU_RST_LEVEL  // Level through reset
) (
    input  wire logic clk,    // Sampling clock
    input  wire logic rst,    // Sync reset, high
    input  wire logic pin,    // Raw asynchronous pin
    output var  logic level   // Filtered level
);

    logic stage1_r;
    logic stage2_r;
    logic stage3_r;

    // Idle-high reset keeps released pins from looking like edges
    wire logic agree     = (stage2_r == stage3_r);
    wire logic level_nxt = agree ? stage3_r : level;

    always_ff @(posedge clk) begin
        if (rst) begin
            stage1_r <= IDLE_LEVEL;
            stage2_r <= IDLE_LEVEL;
            stage3_r <= IDLE_LEVEL;
            level    <= IDLE_LEVEL;
        end else begin
            stage1_r <= pin;
            stage2_r <= stage1_r;
            stage3_r <= stage2_r;
            level    <= level_nxt;
        end
    end

endmodule

`default_nettype wire

// file: kwu_key_wake_unit_properties.sv
/* Port checker of the key wake unit, bound to its top module.
   Assumes one clock MCLK and the synchronous high reset RST. */
`timescale 1ns/1ns
`default_nettype none
module kwu_props (
    input wire logic       MCLK,      // Clock
    input wire logic       RST,       // Reset
    input wire logic [3:0] ADDR,      // Address
    input wire logic       RD,        // Read
    input wire logic [7:0] RDATA,     // Read data
    input wire logic [7:0] PORT_DIR,  // Dir in
    input wire logic [7:0] PORT_PULL, // Pull in
    input wire logic       STOP_MODE, // Stop
    input wire logic [7:0] PIN_DIR,   // Dir out
    input wire logic [7:0] PULL_UP,   // Pullups
    input wire logic [7:0] PULL_DOWN, // Pulldowns
    input wire logic       KEY_IRQ,   // Request
    input wire logic       IRQ,       // Irq
    input wire logic       WAKE       // Wake
);
    // =====
    // Relations
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);
    chk_dir_forced: assert property (!$past(RST) |->
        (PIN_DIR & ~$past(PORT_DIR)) == 8'h00) else $error("dir");
    chk_pull_kept: assert property (!$past(RST) |->
        (PULL_UP | PULL_DOWN) == $past(PORT_PULL)) else $error("pull");
    chk_pull_apart: assert property (
        (PULL_UP & PULL_DOWN) == 8'h00) else $error("pull twice");
    chk_low_pullup: assert property (
        PULL_DOWN[3:0] == 4'h0) else $error("low pulldown");
    chk_ack_zero: assert property ($past(RD) && $past(ADDR) == 4'h0
        |-> !RDATA[2]) else $error("ack read");
    chk_req_follows: assert property ($past(RD) && $past(ADDR) == 4'h0
        |-> $past(KEY_IRQ) == (RDATA[3] & RDATA[1])) else $error("req");
    chk_wake_run: assert property (!$past(STOP_MODE)
        |-> WAKE == KEY_IRQ) else $error("wake");
    chk_read_idle: assert property (!$past(RD)
        |-> RDATA == 8'h00) else $error("rdata");
    cover property (KEY_IRQ && RDATA[3]);
    cover property (STOP_MODE && WAKE);
    cover property ($rose(IRQ));
endmodule
bind kwu_key_wake_unit kwu_props chk_u (
    .MCLK(MCLK), .RST(RST), .ADDR(ADDR), .RD(RD), .RDATA(RDATA),
    .PORT_DIR(PORT_DIR), .PORT_PULL(PORT_PULL), .STOP_MODE(STOP_MODE),
    .PIN_DIR(PIN_DIR), .PULL_UP(PULL_UP), .PULL_DOWN(PULL_DOWN),
    .KEY_IRQ(KEY_IRQ), .IRQ(IRQ), .WAKE(WAKE));
`default_nettype wire

// file: kwu_keys.sv
/* Key model: switches on the eight port pins.
   Assumes the unit drives the pulls; a held key shorts to a rail. */
`timescale 1ns/1ns
`default_nettype none
module kwu_keys (
    input  wire logic       clk,     // Bench clock
    input  wire logic [7:0] press,   // Keys held
    input  wire logic [7:0] pull_up, // Pullups on
    input  wire logic [7:0] pull_dn, // Pulldowns on
    output logic      [7:0] pin      // Pin levels
);
    // =====
    // Unpulled pins drift so a stale level never passes
    logic [7:0] drift_r = 8'h55;
    always @(posedge clk) drift_r <= ~drift_r;
    assign pin = (press & pull_dn) | (~press & (pull_up | (~pull_dn & drift_r)));
endmodule
`default_nettype wire

// file: test_keyboard_wake_interrupt.sv
/* Bench of the key wake unit: registers, key edges, modes, stop wake.
   Assumes kwu_pkg, kwu_keys and the bound checker are compiled first. */
`timescale 1ns/1ns
`default_nettype none
module test_keyboard_wake_interrupt;
    logic        MCLK = 1'b0, RST = 1'b1, WR = 1'b0, RD = 1'b0;
    logic        STOP_MODE = 1'b0, rd_d = 1'b0, KEY_IRQ, IRQ, WAKE;
    logic [3:0]  ADDR = 4'h0;
    logic [7:0]  WDATA = 8'h00, PORT_DIR = 8'h00, press = 8'h00;
    logic [7:0]  RDATA, PIN_IN, PIN_DIR, PULL_UP, PULL_DOWN;
    logic [31:0] seed = 32'h61ad;
    logic [7:0]  en_m = 8'h00, en_d1 = 8'h00, en_d2 = 8'h00, dir_d = 8'h00;
    logic        rst_d = 1'b1;
    logic [9:0]  exp_q[$];
    int          bad_count = 0, checks_done = 0;
    always #4 MCLK = ~MCLK;
    kwu_key_wake_unit dut_u (.MCLK(MCLK), .RST(RST), .ADDR(ADDR),
        .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .PIN_IN(PIN_IN),
        .PORT_DIR(PORT_DIR), .PORT_PULL(8'hff), .STOP_MODE(STOP_MODE),
        .PIN_DIR(PIN_DIR), .PULL_UP(PULL_UP), .PULL_DOWN(PULL_DOWN),
        .KEY_IRQ(KEY_IRQ), .IRQ(IRQ), .WAKE(WAKE));
    kwu_keys keys_u (.clk(MCLK), .press(press), .pull_up(PULL_UP),
        .pull_dn(PULL_DOWN), .pin(PIN_IN));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input logic [9:0] seen, input logic [9:0] want);
        checks_done++;
        if (seen !== want) begin
            bad_count++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, want);
        end
    endtask
    // =====
    // Read results checked as they appear, with both request lines
    always @(posedge MCLK) begin
        seed <= lfsr(seed);
        PORT_DIR <= seed[7:0];
        rd_d <= RD;
        rst_d <= RST;
        dir_d <= PORT_DIR;
        en_d1 <= en_m;
        en_d2 <= en_d1;
        if (!rst_d) check({2'b00, PIN_DIR}, {2'b00, dir_d & ~en_d2});
        if (rd_d) check({IRQ, KEY_IRQ, RDATA}, exp_q.pop_front());
    end
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [7:0] d, input logic [9:0] e);
        WR <= w;
        RD <= !w;
        ADDR <= a;
        WDATA <= d;
        if (!w) exp_q.push_back(e);
        if (w && a == 4'h1) en_m <= d;
        @(posedge MCLK);
    endtask
    task automatic idle(input int n);
        WR <= 1'b0;
        RD <= 1'b0;
        repeat (n) @(posedge MCLK);
    endtask
    task automatic ack(input logic [7:0] s);
        bus(1'b1, 4'h0, s | 8'h04, 10'h0);
        bus(1'b1, 4'h2, 8'h03, 10'h0);
        idle(2);
    endtask
    task automatic final_report;
        $display("checks %0d, mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge MCLK);
        RST <= 1'b0;
        idle(6);
        for (int a = 0; a < 6; a++) bus(1'b0, a[3:0], 8'h00, (a == 4) ? 10'h0ff : 10'h0);
        bus(1'b1, 4'h1, 8'hff, 10'h0);
        bus(1'b1, 4'h3, 8'h01, 10'h0);
        idle(10);
        // Polarity change flips pin 7 view; let it settle before ack
        bus(1'b1, 4'h0, 8'h82, 10'h0);
        idle(10);
        ack(8'h82);
        bus(1'b0, 4'h0, 8'h00, 10'h082);
        // Every pin in turn; pin 7 rises, the rest fall
        for (int i = 0; i < 8; i++) begin
            press[i] <= 1'b1;
            idle(8);
            bus(1'b0, 4'h0, 8'h00, 10'h38a);
            press[i] <= 1'b0;
            idle(8);
            bus(1'b0, 4'h0, 8'h00, 10'h38a);
            ack(8'h82);
            bus(1'b0, 4'h0, 8'h00, 10'h082);
        end
        bus(1'b1, 4'h1, 8'hfe, 10'h0);
        press[0] <= 1'b1;
        idle(8);
        bus(1'b0, 4'h0, 8'h00, 10'h082);
        press[0] <= 1'b0;
        idle(8);
        bus(1'b1, 4'h1, 8'hff, 10'h0);
        ack(8'h83);
        press[1] <= 1'b1;
        idle(8);
        bus(1'b1, 4'h0, 8'h87, 10'h0);
        bus(1'b0, 4'h0, 8'h00, 10'h38b);
        bus(1'b1, 4'h2, 8'h03, 10'h0);
        press[2] <= 1'b1;
        idle(8);
        bus(1'b0, 4'h0, 8'h00, 10'h18b);
        press[1] <= 1'b0;
        press[2] <= 1'b0;
        idle(8);
        ack(8'h80);
        bus(1'b0, 4'h0, 8'h00, 10'h080);
        press[3] <= 1'b1;
        idle(8);
        bus(1'b0, 4'h0, 8'h00, 10'h288);
        press[3] <= 1'b0;
        STOP_MODE <= 1'b1;
        idle(8);
        press[4] <= 1'b1;
        #1;
        repeat (4) @(posedge MCLK);
        #1 check({9'h0, WAKE}, 10'h1);
        press[4] <= 1'b0;
        repeat (4) @(posedge MCLK);
        #1 check({9'h0, WAKE}, 10'h0);
        $display("key scenarios done");
        final_report;
    end
    initial begin
        repeat (20000) @(posedge MCLK);
        bad_count++;
        final_report;
    end
endmodule
`default_nettype wire
